// *** bcr_defs.svh ***
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

// Clock rate and time figures
`define BCR_CLK_MHZ 10
`define BCR_EN_DELAY_US 100
`define BCR_SS_BASE_US 500

// Device register offsets
`define BCR_OFS_SETPOINT 8'h00
`define BCR_OFS_CTRL1 8'h01
`define BCR_OFS_CTRL2 8'h02
`define BCR_OFS_CTRL3 8'h03
`define BCR_OFS_STATUS 8'h04

// Reset values
`define BCR_CTRL1_RST 8'h2A
`define BCR_CTRL2_RST 8'h09
`define BCR_CTRL3_RST 8'h00
`define BCR_STATUS_RST 8'h02

// Field positions
`define BCR_BIT_RESET 7
`define BCR_BIT_SPREAD 6
`define BCR_BIT_SWITCH_ON 5
`define BCR_BIT_FPWM 4
`define BCR_BIT_BLEED 3
`define BCR_BIT_RETRY 2
`define BCR_BIT_STANDALONE 1
`define BCR_BIT_GOOD_BLANK 0
`define BCR_FLAG_COUNT 6

// Masks of implemented bits; the rest reads zero
`define BCR_CTRL2_MASK 8'h0F
`define BCR_CTRL3_MASK 8'h03
`define BCR_STATUS_MASK 8'h3F

// Setpoint scale in 1.25 mV units
`define BCR_BASE_LOW 12'h140
`define BCR_BASE_HIGH 12'h280
`define BCR_RANGE_HIGH 2'h3

// Slew in 0.25 mV/us units
`define BCR_SLEW_00 6'h28
`define BCR_SLEW_01 6'h14
`define BCR_SLEW_10 6'h05
`define BCR_SLEW_11 6'h02

// Host command register offsets and bits
`define BCR_H_OFS_TADDR 3'h0
`define BCR_H_OFS_TDATA 3'h1
`define BCR_H_OFS_CMD 3'h2
`define BCR_H_OFS_RESULT 3'h3
`define BCR_H_OFS_STATE 3'h4
`define BCR_H_CMD_WRITE 0
`define BCR_H_CMD_READ 1

`endif

// *** bcr_pkg.sv ***
`default_nettype none
package bcr_pkg;
   // Device startup sequence
   typedef enum logic [2:0] {
      BCR_ST_DELAY = 3'b001,
      BCR_ST_RAMP = 3'b010,
      BCR_ST_RUN = 3'b100
   } bcr_dev_state_type;

   // Host access sequence
   typedef enum logic [2:0] {
      BCR_HS_IDLE = 3'b001,
      BCR_HS_ISSUE = 3'b010,
      BCR_HS_CAPTURE = 3'b100
   } bcr_host_state_type;
endpackage
`default_nettype wire

// *** bcr_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface bcr_link_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;

   modport device (input addr, input wdata, input wr, input rd, output rdata);
   modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// *** bcr_flag_bit.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcr_flag_bit #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic clr_i,
   input wire logic srst_i,
   output logic flag_o
);
   logic flag_reg;
   logic flag_next;

   // Sticky flag, event beats read clear
   always_comb begin
      flag_next = flag_reg;
      if (srst_i) begin
         flag_next = RST_VAL;
      end else if (set_i) begin
         flag_next = 1'b1;
      end else if (clr_i) begin
         flag_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flag_reg <= RST_VAL;
      end else if (ce_i) begin
         flag_reg <= flag_next;
      end
   end

   assign flag_o = flag_reg;
endmodule // bcr_flag_bit
`default_nettype wire

// *** bcr_device.sv ***
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "bcr_defs.svh"
module bcr_device #(
   parameter int unsigned EN_DELAY_CYCLES = `BCR_EN_DELAY_US * `BCR_CLK_MHZ,
   parameter int unsigned SS_BASE_CYCLES = `BCR_SS_BASE_US * `BCR_CLK_MHZ
) (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   bcr_link_if.device LINK,
   input wire logic MODE_SYNC_ACTIVE_I,
   input wire logic [7:0] SETPOINT_CODE_I,
   input wire logic DYNAMIC_VOLTAGE_CHANGE_I,
   input wire logic WINDOW_OK_I,
   input wire logic [5:0] EVENT_I,
   output logic SWITCHING_O,
   output logic STARTUP_RAMP_O,
   output logic [19:0] RAMP_CYCLES_O,
   output logic SPREAD_SPECTRUM_ON_O,
   output logic FORCED_FIXED_FREQ_ON_O,
   output logic OUTPUT_BLEED_ON_O,
   output logic RETRY_RECOVERY_ON_O,
   output logic [5:0] SLEW_RATE_O,
   output logic [11:0] SETPOINT_O,
   output logic EN_PULLDOWN_ON_O,
   output logic CLOCK_FOLLOW_OUT_ON_O,
   output logic POWER_GOOD_OUT_O,
   output logic POWER_GOOD_OE_O
);
   localparam logic [19:0] DELAY_LAST = 20'(EN_DELAY_CYCLES - 1);
   localparam logic [19:0] SS_BASE = 20'(SS_BASE_CYCLES);

   logic [6:0] ctrl1_reg;
   logic [6:0] ctrl1_next;
   logic [3:0] ctrl2_reg;
   logic [3:0] ctrl2_next;
   logic [1:0] ctrl3_reg;
   logic [1:0] ctrl3_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   bcr_pkg::bcr_dev_state_type state_reg;
   bcr_pkg::bcr_dev_state_type state_next;
   logic [19:0] cnt_reg;
   logic [19:0] cnt_next;
   logic [19:0] ramp_reg;
   logic [19:0] ramp_next;
   logic [11:0] setpoint_reg;
   logic [11:0] setpoint_next;
   logic [5:0] slew_reg;
   logic [5:0] slew_next;
   logic fpwm_reg;
   logic fpwm_next;
   logic good_out_reg;
   logic good_out_next;
   logic good_oe_reg;
   logic good_oe_next;
   logic soft_reset;
   logic status_clr;
   logic [5:0] flags;
   logic [19:0] ss_len;

   // Sticky status flags, one per event
   genvar gi;
   generate
      for (gi = 0; gi < `BCR_FLAG_COUNT; gi++) begin : g_flag
         bcr_flag_bit #(
            .RST_VAL(1'(`BCR_STATUS_RST >> gi))
         ) u_flag (
            .clk_i(CORE_CLK_I),
            .nrst_i(NRST_I),
            .ce_i(CE_I),
            .set_i(EVENT_I[gi]),
            .clr_i(status_clr),
            .srst_i(soft_reset),
            .flag_o(flags[gi])
         );
      end
   endgenerate

   // Read of status clears all flags except one whose event is raised in the same cycle
   assign status_clr = LINK.rd && (LINK.addr == `BCR_OFS_STATUS);
   assign ss_len = (SS_BASE << ctrl2_reg[1:0]) - 20'h00001;

   // Register file, startup sequence and derived outputs
   always_comb begin
      ctrl1_next = ctrl1_reg;
      ctrl2_next = ctrl2_reg;
      ctrl3_next = ctrl3_reg;
      rdata_next = 8'h00;
      state_next = state_reg;
      cnt_next = cnt_reg;
      ramp_next = ramp_reg;
      soft_reset = 1'b0;
      // Writes refused until the enable delay has run out
      if (LINK.wr && (state_reg != bcr_pkg::BCR_ST_DELAY)) begin
         case (LINK.addr)
            `BCR_OFS_CTRL1: begin
               if (LINK.wdata[`BCR_BIT_RESET]) begin
                  soft_reset = 1'b1;
               end else begin
                  ctrl1_next = LINK.wdata[6:0];
               end
            end
            `BCR_OFS_CTRL2: ctrl2_next = LINK.wdata[3:0];
            `BCR_OFS_CTRL3: ctrl3_next = LINK.wdata[1:0];
            default: ;
         endcase
      end
      if (LINK.rd) begin
         case (LINK.addr)
            `BCR_OFS_CTRL1: rdata_next = {1'b0, ctrl1_reg};
            `BCR_OFS_CTRL2: rdata_next = {4'h0, ctrl2_reg};
            `BCR_OFS_CTRL3: rdata_next = {6'h00, ctrl3_reg};
            `BCR_OFS_STATUS: rdata_next = {2'b00, flags};
            default: rdata_next = 8'h00;
         endcase
      end
      // Enable delay, then soft-start ramp, then run
      case (state_reg)
         bcr_pkg::BCR_ST_DELAY: begin
            if (cnt_reg == 20'h00000) begin
               state_next = bcr_pkg::BCR_ST_RAMP;
               cnt_next = ss_len;
               ramp_next = ss_len + 20'h00001;
            end else begin
               cnt_next = cnt_reg - 20'h00001;
            end
         end
         bcr_pkg::BCR_ST_RAMP: begin
            if (cnt_reg == 20'h00000) begin
               state_next = bcr_pkg::BCR_ST_RUN;
            end else begin
               cnt_next = cnt_reg - 20'h00001;
            end
         end
         bcr_pkg::BCR_ST_RUN: ;
         default: begin
            state_next = bcr_pkg::BCR_ST_DELAY;
            cnt_next = DELAY_LAST;
         end
      endcase
      if (soft_reset) begin
         ctrl1_next = 7'(`BCR_CTRL1_RST);
         ctrl2_next = 4'(`BCR_CTRL2_RST);
         ctrl3_next = 2'(`BCR_CTRL3_RST);
         state_next = bcr_pkg::BCR_ST_DELAY;
         cnt_next = DELAY_LAST;
      end
      // Setpoint in 1.25 mV units
      setpoint_next = ((ctrl2_reg[3:2] == `BCR_RANGE_HIGH) ? `BCR_BASE_HIGH : `BCR_BASE_LOW)
         + ({4'h0, SETPOINT_CODE_I} << ctrl2_reg[3:2]);
      case (ctrl1_reg[1:0])
         2'h0: slew_next = `BCR_SLEW_00;
         2'h1: slew_next = `BCR_SLEW_01;
         2'h2: slew_next = `BCR_SLEW_10;
         default: slew_next = `BCR_SLEW_11;
      endcase
      fpwm_next = ctrl1_reg[`BCR_BIT_FPWM] | MODE_SYNC_ACTIVE_I;
      good_out_next = WINDOW_OK_I;
      good_oe_next = !(ctrl3_reg[`BCR_BIT_GOOD_BLANK] && DYNAMIC_VOLTAGE_CHANGE_I);
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ctrl1_reg <= 7'(`BCR_CTRL1_RST);
         ctrl2_reg <= 4'(`BCR_CTRL2_RST);
         ctrl3_reg <= 2'(`BCR_CTRL3_RST);
         rdata_reg <= 8'h00;
         state_reg <= bcr_pkg::BCR_ST_DELAY;
         cnt_reg <= DELAY_LAST;
         ramp_reg <= 20'h00000;
         setpoint_reg <= 12'h000;
         slew_reg <= 6'h00;
         fpwm_reg <= 1'b0;
         good_out_reg <= 1'b0;
         good_oe_reg <= 1'b1;
      end else if (CE_I) begin
         ctrl1_reg <= ctrl1_next;
         ctrl2_reg <= ctrl2_next;
         ctrl3_reg <= ctrl3_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ramp_reg <= ramp_next;
         setpoint_reg <= setpoint_next;
         slew_reg <= slew_next;
         fpwm_reg <= fpwm_next;
         good_out_reg <= good_out_next;
         good_oe_reg <= good_oe_next;
      end
   end

   // Outputs from registers, some through gates on register bits
   assign LINK.rdata = rdata_reg;
   assign SWITCHING_O = ctrl1_reg[`BCR_BIT_SWITCH_ON]
      && (state_reg != bcr_pkg::BCR_ST_DELAY);
   assign STARTUP_RAMP_O = (state_reg == bcr_pkg::BCR_ST_RAMP);
   assign RAMP_CYCLES_O = ramp_reg;
   assign SPREAD_SPECTRUM_ON_O = ctrl1_reg[`BCR_BIT_SPREAD];
   assign FORCED_FIXED_FREQ_ON_O = fpwm_reg;
   assign OUTPUT_BLEED_ON_O = ctrl1_reg[`BCR_BIT_BLEED];
   assign RETRY_RECOVERY_ON_O = ctrl1_reg[`BCR_BIT_RETRY];
   assign SLEW_RATE_O = slew_reg;
   assign SETPOINT_O = setpoint_reg;
   assign EN_PULLDOWN_ON_O = !ctrl3_reg[`BCR_BIT_STANDALONE];
   assign CLOCK_FOLLOW_OUT_ON_O = !ctrl3_reg[`BCR_BIT_STANDALONE];
   assign POWER_GOOD_OUT_O = good_out_reg;
   assign POWER_GOOD_OE_O = good_oe_reg;
endmodule // bcr_device
`default_nettype wire

// *** bcr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bcr_defs.svh"
module bcr_host (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic [2:0] HOST_ADDR_I,
   input wire logic [7:0] HOST_WDATA_I,
   input wire logic HOST_WR_I,
   input wire logic HOST_RD_I,
   output logic [7:0] HOST_RDATA_O,
   input wire logic STACKED_I,
   bcr_link_if.host LINK
);
   bcr_pkg::bcr_host_state_type state_reg;
   bcr_pkg::bcr_host_state_type state_next;
   logic [7:0] taddr_reg;
   logic [7:0] taddr_next;
   logic [7:0] tdata_reg;
   logic [7:0] tdata_next;
   logic [7:0] result_reg;
   logic [7:0] result_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] lwdata_reg;
   logic [7:0] lwdata_next;
   logic wr_reg;
   logic wr_next;
   logic rd_reg;
   logic rd_next;
   logic done_reg;
   logic done_next;
   logic busy;
   logic [7:0] safe_data;

   assign busy = (state_reg != bcr_pkg::BCR_HS_IDLE);

   // Reserved bits zeroed, stacking-unsafe bits dropped
   always_comb begin
      safe_data = tdata_reg;
      case (taddr_reg)
         `BCR_OFS_CTRL1: begin
            if (STACKED_I) begin
               safe_data[`BCR_BIT_RETRY] = 1'b0;
            end
         end
         `BCR_OFS_CTRL2: safe_data = tdata_reg & `BCR_CTRL2_MASK;
         `BCR_OFS_CTRL3: begin
            safe_data = tdata_reg & `BCR_CTRL3_MASK;
            if (STACKED_I) begin
               safe_data[`BCR_BIT_STANDALONE] = 1'b0;
            end
         end
         default: ;
      endcase
   end

   // Command registers and link sequence
   always_comb begin
      state_next = state_reg;
      taddr_next = taddr_reg;
      tdata_next = tdata_reg;
      result_next = result_reg;
      lwdata_next = lwdata_reg;
      wr_next = 1'b0;
      rd_next = 1'b0;
      done_next = done_reg;
      rdata_next = 8'h00;
      if (HOST_RD_I) begin
         case (HOST_ADDR_I)
            `BCR_H_OFS_TADDR: rdata_next = taddr_reg;
            `BCR_H_OFS_TDATA: rdata_next = tdata_reg;
            `BCR_H_OFS_RESULT: rdata_next = result_reg;
            `BCR_H_OFS_STATE: begin
               rdata_next = {6'h00, done_reg, busy};
               done_next = 1'b0;
            end
            default: rdata_next = 8'h00;
         endcase
      end
      if (HOST_WR_I && !busy) begin
         case (HOST_ADDR_I)
            `BCR_H_OFS_TADDR: taddr_next = HOST_WDATA_I;
            `BCR_H_OFS_TDATA: tdata_next = HOST_WDATA_I;
            `BCR_H_OFS_CMD: begin
               if (HOST_WDATA_I[`BCR_H_CMD_WRITE]) begin
                  wr_next = 1'b1;
                  lwdata_next = safe_data;
                  state_next = bcr_pkg::BCR_HS_ISSUE;
               end else if (HOST_WDATA_I[`BCR_H_CMD_READ]) begin
                  rd_next = 1'b1;
                  state_next = bcr_pkg::BCR_HS_ISSUE;
               end
            end
            default: ;
         endcase
      end
      case (state_reg)
         bcr_pkg::BCR_HS_IDLE: ;
         bcr_pkg::BCR_HS_ISSUE: begin
            if (rd_reg) begin
               state_next = bcr_pkg::BCR_HS_CAPTURE;
            end else begin
               state_next = bcr_pkg::BCR_HS_IDLE;
               done_next = 1'b1;
            end
         end
         bcr_pkg::BCR_HS_CAPTURE: begin
            result_next = LINK.rdata;
            if (taddr_reg == `BCR_OFS_STATUS) begin
               result_next = LINK.rdata & `BCR_STATUS_MASK;
            end
            state_next = bcr_pkg::BCR_HS_IDLE;
            done_next = 1'b1;
         end
         default: state_next = bcr_pkg::BCR_HS_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_reg <= bcr_pkg::BCR_HS_IDLE;
         taddr_reg <= 8'h00;
         tdata_reg <= 8'h00;
         result_reg <= 8'h00;
         rdata_reg <= 8'h00;
         lwdata_reg <= 8'h00;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (CE_I) begin
         state_reg <= state_next;
         taddr_reg <= taddr_next;
         tdata_reg <= tdata_next;
         result_reg <= result_next;
         rdata_reg <= rdata_next;
         lwdata_reg <= lwdata_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         done_reg <= done_next;
      end
   end

   // Link driven from flops
   assign LINK.addr = taddr_reg;
   assign LINK.wdata = lwdata_reg;
   assign LINK.wr = wr_reg;
   assign LINK.rd = rd_reg;
   assign HOST_RDATA_O = rdata_reg;
endmodule // bcr_host
`default_nettype wire

// *** bcr_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module bcr_link_checker (
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic MODE_SYNC_ACTIVE_I,
   input wire logic WINDOW_OK_I,
   input wire logic SWITCHING_O,
   input wire logic FORCED_FIXED_FREQ_ON_O,
   input wire logic POWER_GOOD_OUT_O,
   input wire logic EN_PULLDOWN_ON_O,
   input wire logic CLOCK_FOLLOW_OUT_ON_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);

   // Link read of one offset, and a soft reset taken while running
   sequence s_read(logic [7:0] ofs);
      CE_I && rd && addr == ofs;
   endsequence
   sequence s_soft_reset;
      CE_I && wr && addr == 8'h01 && wdata[7] && SWITCHING_O;
   endsequence
   sequence s_delay_seen;
      s_soft_reset ##1 !SWITCHING_O [*3];
   endsequence

   // Read data of each control and status register
   a_reset_bit_low: assert property (s_read(8'h01) |=> rdata[7] == 1'b0)
      else $error("reset bit read back as one");
   a_ctrl2_reserved: assert property (s_read(8'h02) |=> rdata[7:4] == 4'h0)
      else $error("control two upper bits nonzero");
   a_ctrl3_reserved: assert property (s_read(8'h03) |=> rdata[7:2] == 6'h00)
      else $error("control three upper bits nonzero");
   a_status_reserved: assert property (s_read(8'h04) |=> rdata[7:6] == 2'h0)
      else $error("status upper bits nonzero");

   // Switching control
   a_soft_reset_stop: assert property (s_soft_reset |=> !SWITCHING_O [*3])
      else $error("switching during enable delay");
   a_soft_reset_restart: assert property (s_delay_seen |-> ##[1:8] SWITCHING_O)
      else $error("no restart after soft reset");
   a_switch_stop: assert property (SWITCHING_O && CE_I && wr && addr == 8'h01
      && !wdata[7] && !wdata[5] |=> !SWITCHING_O)
      else $error("switching kept after enable cleared");

   // Pin driven outputs, and the pulldown and follow out pair
   a_fixed_freq_pin: assert property ($past(NRST_I) && $past(CE_I)
      && $past(MODE_SYNC_ACTIVE_I) |-> FORCED_FIXED_FREQ_ON_O)
      else $error("fixed frequency ignores mode pin");
   a_good_follow: assert property ($past(NRST_I) && $past(CE_I)
      |-> POWER_GOOD_OUT_O == $past(WINDOW_OK_I))
      else $error("power good not following window");
   a_follow_pair: assert property (EN_PULLDOWN_ON_O == CLOCK_FOLLOW_OUT_ON_O)
      else $error("pulldown and follow out differ");
   // Standalone bit written while running drives both outputs
   a_standalone_write: assert property (SWITCHING_O && CE_I && wr && addr == 8'h03
      |=> EN_PULLDOWN_ON_O == !$past(wdata[1]))
      else $error("pulldown ignores standalone bit");
endmodule // bcr_link_checker
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic [2:0] haddr = 3'h0;
   logic [7:0] hwdata = 8'h00;
   logic hwr = 1'b0;
   logic hrd = 1'b0;
   logic stacked = 1'b0;
   logic mode = 1'b0;
   logic dvc = 1'b0;
   logic win = 1'b0;
   logic [7:0] code = 8'h10;
   logic [5:0] ev = 6'h00;
   logic [7:0] hrdata;
   logic sw, ramp, ssc, ffq, bleed, retry, pd, fol, good, good_oe;
   logic [19:0] ramp_cyc;
   logic [5:0] slew;
   logic [11:0] sp;
   logic [7:0] v;
   logic [5:0] slew_tab [4] = '{6'h28, 6'h14, 6'h05, 6'h02};
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;
   int k;

   // Clock and hang guard
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         results();
      end
   end

   bcr_link_if bcr_link_if_i ();
   bcr_device #(.EN_DELAY_CYCLES(4), .SS_BASE_CYCLES(8)) bcr_device_i (
      .CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .LINK(bcr_link_if_i),
      .MODE_SYNC_ACTIVE_I(mode), .SETPOINT_CODE_I(code), .DYNAMIC_VOLTAGE_CHANGE_I(dvc),
      .WINDOW_OK_I(win), .EVENT_I(ev), .SWITCHING_O(sw), .STARTUP_RAMP_O(ramp),
      .RAMP_CYCLES_O(ramp_cyc), .SPREAD_SPECTRUM_ON_O(ssc), .FORCED_FIXED_FREQ_ON_O(ffq),
      .OUTPUT_BLEED_ON_O(bleed), .RETRY_RECOVERY_ON_O(retry), .SLEW_RATE_O(slew),
      .SETPOINT_O(sp), .EN_PULLDOWN_ON_O(pd), .CLOCK_FOLLOW_OUT_ON_O(fol),
      .POWER_GOOD_OUT_O(good), .POWER_GOOD_OE_O(good_oe));
   bcr_host bcr_host_i (
      .CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .HOST_ADDR_I(haddr),
      .HOST_WDATA_I(hwdata), .HOST_WR_I(hwr), .HOST_RD_I(hrd), .HOST_RDATA_O(hrdata),
      .STACKED_I(stacked), .LINK(bcr_link_if_i));
   bcr_link_checker bcr_link_checker_i (
      .CORE_CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .addr(bcr_link_if_i.addr),
      .wdata(bcr_link_if_i.wdata), .wr(bcr_link_if_i.wr), .rd(bcr_link_if_i.rd),
      .rdata(bcr_link_if_i.rdata), .MODE_SYNC_ACTIVE_I(mode), .WINDOW_OK_I(win),
      .SWITCHING_O(sw), .FORCED_FIXED_FREQ_ON_O(ffq), .POWER_GOOD_OUT_O(good),
      .EN_PULLDOWN_ON_O(pd), .CLOCK_FOLLOW_OUT_ON_O(fol));

   // Compare and report
   task automatic chk(input logic [19:0] s, input logic [19:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Host port write and read, one cycle strobes
   task automatic hw(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      haddr <= a;
      hwdata <= d;
      hwr <= 1'b1;
      @(posedge clk);
      hwr <= 1'b0;
   endtask
   task automatic hr(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      haddr <= a;
      hrd <= 1'b1;
      @(posedge clk);
      hrd <= 1'b0;
      #1 d = hrdata;
   endtask
   // Device register access through the host commands
   task automatic dw(input logic [7:0] a, input logic [7:0] d);
      hw(3'h0, a);
      hw(3'h1, d);
      hw(3'h2, 8'h01);
      tick(3);
   endtask
   task automatic dr(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      hw(3'h0, a);
      hw(3'h2, 8'h02);
      repeat (4) @(posedge clk);
      hr(3'h3, r);
      chk(r, e);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      tick(10);
      chk({ssc, bleed, retry}, 3'b010);
      chk(slew, 6'h05);
      chk(sp, 12'h180);
      chk({pd, fol}, 2'b11);
      chk(ramp, 1'b1);
      dr(8'h01, 8'h2A);
      dr(8'h02, 8'h09);
      dr(8'h03, 8'h00);
      dr(8'h04, 8'h02);
      dr(8'h04, 8'h00);
      dr(8'h05, 8'h00);
      hr(3'h6, v);
      chk(v, 8'h00);
      hr(3'h4, v);
      chk(v, 8'h02); // Done left by the last command
      hr(3'h4, v);
      chk(v, 8'h00); // Done cleared by the read
      $display("test reset values done");
      for (k = 0; k < 4; k++) begin
         dw(8'h01, {6'h0A, k[1:0]});
         chk(slew, slew_tab[k]);
         dw(8'h02, {4'h0, k[1:0], 2'b01});
         chk(sp, k == 3 ? 12'h280 + {1'b0, code, 3'h0} : 12'h140 + ({4'h0, code} << k));
         dr(8'h02, {4'h0, k[1:0], 2'b01});
      end
      $display("test slew and scale done");
      dw(8'h01, 8'h5C);
      chk(sw, 1'b0);
      chk({ssc, ffq, bleed, retry}, 4'hF);
      dr(8'h01, 8'h5C);
      dw(8'h01, 8'h20);
      chk(sw, 1'b1);
      chk({ssc, ffq, bleed, retry}, 4'h0);
      @(posedge clk) mode <= 1'b1;
      tick(2);
      chk(ffq, 1'b1);
      @(posedge clk) mode <= 1'b0;
      $display("test control one done");
      dw(8'h03, 8'h03);
      chk({pd, fol}, 2'b00);
      @(posedge clk) dvc <= 1'b1;
      tick(2);
      chk(good_oe, 1'b0);
      @(posedge clk) dvc <= 1'b0;
      tick(2);
      chk(good_oe, 1'b1);
      dw(8'h03, 8'h00);
      @(posedge clk) begin
         dvc <= 1'b1;
         win <= 1'b1;
      end
      tick(2);
      chk({good_oe, good}, 2'b11);
      @(posedge clk) dvc <= 1'b0;
      $display("test control three done");
      @(posedge clk) ev <= 6'h3D;
      @(posedge clk) ev <= 6'h00;
      dr(8'h04, 8'h3D);
      dr(8'h04, 8'h00);
      @(posedge clk) ev <= 6'h02;
      @(posedge clk) ev <= 6'h00;
      dr(8'h04, 8'h02);
      // Event raised only at the edge that clears the flags
      hw(3'h0, 8'h04);
      hw(3'h2, 8'h02);
      ev <= 6'h02;
      @(posedge clk) ev <= 6'h00;
      repeat (3) @(posedge clk);
      hr(3'h3, v);
      chk(v, 8'h00);
      dr(8'h04, 8'h02);
      dr(8'h04, 8'h00);
      $display("test flags done");
      @(posedge clk) stacked <= 1'b1;
      dw(8'h01, 8'h2C);
      dr(8'h01, 8'h28);
      dw(8'h03, 8'h02);
      dr(8'h03, 8'h00);
      @(posedge clk) stacked <= 1'b0;
      dw(8'h03, 8'hFC);
      dr(8'h03, 8'h00);
      $display("test stacked done");
      dw(8'h02, 8'h00);
      dw(8'h01, 8'h80);
      chk(sw, 1'b0);
      tick(3);
      chk(ramp, 1'b1);
      dr(8'h02, 8'h09);
      dr(8'h01, 8'h2A);
      dr(8'h04, 8'h02);
      chk(ramp_cyc, 20'd16);
      chk(sw, 1'b1);
      chk(ramp, 1'b0);
      $display("test soft reset done");
      // Event while frozen must not latch
      @(posedge clk) ce <= 1'b0;
      @(posedge clk) ev <= 6'h01;
      @(posedge clk) ev <= 6'h00;
      @(posedge clk) ce <= 1'b1;
      dr(8'h04, 8'h00);
      $display("test clock enable done");
      results();
   end
endmodule // tb_top
`default_nettype wire
